// file: tm2_pkg.sv
`default_nettype none
package tm2_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_MODE     = 8'h04;
  localparam logic [7:0]  OFS_COUNT    = 8'h08;
  localparam logic [7:0]  OFS_RELOAD   = 8'h0c;

  // ----------------------------------------------------------------
  // timer_control_reg fields
  // ----------------------------------------------------------------
  localparam int          CTRL_CP_RL   = 0;
  localparam int          CTRL_CT_SEL  = 1;
  localparam int          CTRL_RUN     = 2;
  localparam int          CTRL_TRIG_EN = 3;
  localparam int          CTRL_TX_BAUD = 4;
  localparam int          CTRL_RX_BAUD = 5;
  localparam int          CTRL_EXT_F   = 6;
  localparam int          CTRL_OVF_F   = 7;

  // ----------------------------------------------------------------
  // timer_mode_reg fields
  // ----------------------------------------------------------------
  localparam int          MODE_DOWN_COUNT_ENABLE    = 0;
  localparam int          MODE_OE      = 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          OSC_PER_MC   = 12;
  localparam logic [3:0]  PHASE_LAST   = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  SAMPLE_PH    = 4'h9;
  localparam logic [3:0]  UPDATE_PH    = 4'h4;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CNT_RESET    = 16'h0000;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    TM2_OFF     = 3'h0,
    TM2_RELOAD  = 3'h1,
    TM2_CAPTURE = 3'h2,
    TM2_BAUD    = 3'h3,
    TM2_CLKOUT  = 3'h4
  } tm2_mode_e;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tm2_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tm2_axi_rsp_s;

endpackage
`default_nettype wire

// file: tm2_timer.sv
`default_nettype none
module tm2_timer
  import tm2_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  input  wire tm2_pkg::tm2_axi_req_s S_AXI_REQ,
  output var  tm2_pkg::tm2_axi_rsp_s S_AXI_RSP,
  input  wire logic                  CLOCK_OUTPUT_PIN_I,
  output logic                       CLOCK_OUTPUT_PIN_O,
  output logic                       CLOCK_OUTPUT_PIN_OE_B,
  input  wire logic                  TRIGGER_PIN,
  output logic                       BAUD_TICK,
  output logic                       TIMER_IRQ
);

  import tm2_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  phase;
    logic        half;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        cp_rl;
    logic        ct_sel;
    logic        run;
    logic        trig_en;
    logic        tx_baud;
    logic        rx_baud;
    logic        ext_f;
    logic        ovf_f;
    logic        down_count_enable;
    logic        oe_en;
    logic        cnt_s1;
    logic        cnt_s2;
    logic        trg_s1;
    logic        trg_s2;
    logic        cnt_smp;
    logic        trg_smp;
    logic        pend;
    logic        clk_out;
    logic        pin_oe_b;
    logic        baud_tick;
    logic        irq;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        aw_rdy;
    logic        w_rdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_rdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tm2_state_s;

  tm2_state_s st_q;
  tm2_state_s st_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    tm2_mode_e   mode;
    logic        mc_upd;
    logic        mc_smp;
    logic        clkout_mode;
    logic        tick;
    logic        trg_fall;
    logic        wr_go;
    logic        wr_ok;
    logic        cnt_wr;
    logic        rld_wr;
    logic [15:0] cnt_wval;
    logic [15:0] rld_wval;
    logic [7:0]  b0;

    st_d        = st_q;
    mode        = TM2_OFF;
    mc_upd      = 1'b0;
    mc_smp      = 1'b0;
    clkout_mode = 1'b0;
    tick        = 1'b0;
    trg_fall    = 1'b0;
    wr_go       = 1'b0;
    wr_ok       = 1'b0;
    cnt_wr      = 1'b0;
    rld_wr      = 1'b0;
    cnt_wval    = st_q.cnt;
    rld_wval    = st_q.rld;
    b0          = st_q.wdata[7:0];

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    st_d.cnt_s1 = CLOCK_OUTPUT_PIN_I;
    st_d.cnt_s2 = st_q.cnt_s1;
    st_d.trg_s1 = TRIGGER_PIN;
    st_d.trg_s2 = st_q.trg_s1;

    // ----------------------------------------------------------------
    // machine cycle phase and half-rate enable
    // ----------------------------------------------------------------
    st_d.phase  = (st_q.phase == PHASE_LAST) ? 4'h0 : st_q.phase + 4'h1;
    st_d.half   = ~st_q.half;
    mc_upd      = (st_q.phase == UPDATE_PH);
    mc_smp      = (st_q.phase == SAMPLE_PH);

    // one sample per machine cycle; a level shorter than that may be missed
    if (mc_smp)
    begin
      st_d.cnt_smp = st_q.cnt_s2;
      st_d.trg_smp = st_q.trg_s2;
      if (st_q.cnt_smp && !st_q.cnt_s2)
      begin
        st_d.pend = 1'b1;
      end
      trg_fall = st_q.trg_smp && !st_q.trg_s2;
    end
    if (mc_upd)
    begin
      st_d.pend = 1'b0;
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    clkout_mode = st_q.oe_en && !st_q.ct_sel;
    if (!st_q.run)
    begin
      mode = TM2_OFF;
    end
    else if (st_q.tx_baud || st_q.rx_baud)
    begin
      mode = TM2_BAUD;
    end
    else if (clkout_mode)
    begin
      mode = TM2_CLKOUT;
    end
    else if (st_q.cp_rl)
    begin
      mode = TM2_CAPTURE;
    end
    else
    begin
      mode = TM2_RELOAD;
    end

    // event counts land at the update phase of the next machine cycle
    if (st_q.ct_sel)
    begin
      tick = mc_upd && st_q.pend;
    end
    else if (mode == TM2_BAUD || mode == TM2_CLKOUT)
    begin
      tick = st_q.half;
    end
    else
    begin
      tick = mc_upd;
    end

    // ----------------------------------------------------------------
    // software writes of control, mode and flags (hardware set wins later)
    // ----------------------------------------------------------------
    wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    wr_ok = (st_q.aw_addr[7:4] == 4'h0);
    if (wr_go && wr_ok)
    begin
      case ({st_q.aw_addr[3:2], 2'b00})
        OFS_CTRL[3:0]:
        begin
          if (st_q.wstrb[0])
          begin
            st_d.cp_rl   = b0[CTRL_CP_RL];
            st_d.ct_sel  = b0[CTRL_CT_SEL];
            st_d.run     = b0[CTRL_RUN];
            st_d.trig_en = b0[CTRL_TRIG_EN];
            st_d.tx_baud = b0[CTRL_TX_BAUD];
            st_d.rx_baud = b0[CTRL_RX_BAUD];
            st_d.ext_f   = b0[CTRL_EXT_F];
            st_d.ovf_f   = b0[CTRL_OVF_F];
          end
        end
        OFS_MODE[3:0]:
        begin
          if (st_q.wstrb[0])
          begin
            st_d.down_count_enable  = b0[MODE_DOWN_COUNT_ENABLE];
            st_d.oe_en = b0[MODE_OE];
          end
        end
        OFS_COUNT[3:0]:
        begin
          cnt_wr   = |st_q.wstrb[1:0];
          cnt_wval = {st_q.wstrb[1] ? st_q.wdata[15:8] : st_q.cnt[15:8],
                      st_q.wstrb[0] ? st_q.wdata[7:0]  : st_q.cnt[7:0]};
        end
        OFS_RELOAD[3:0]:
        begin
          rld_wr   = |st_q.wstrb[1:0];
          rld_wval = {st_q.wstrb[1] ? st_q.wdata[15:8] : st_q.rld[15:8],
                      st_q.wstrb[0] ? st_q.wdata[7:0]  : st_q.rld[7:0]};
        end
        default:
        begin
          cnt_wr = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    st_d.baud_tick = 1'b0;
    if (tick)
    begin
      case (mode)
        TM2_BAUD, TM2_CLKOUT:
        begin
          if (st_q.cnt == CNT_ALL_ONES)
          begin
            st_d.cnt = st_q.rld;
            st_d.baud_tick = (mode == TM2_BAUD);
            if (clkout_mode)
            begin
              st_d.clk_out = ~st_q.clk_out;
            end
          end
          else
          begin
            st_d.cnt = st_q.cnt + 16'h1;
          end
        end
        TM2_CAPTURE:
        begin
          st_d.cnt = st_q.cnt + 16'h1;
          if (st_q.cnt == CNT_ALL_ONES)
          begin
            st_d.ovf_f = 1'b1;
          end
        end
        TM2_RELOAD:
        begin
          if (st_q.down_count_enable && !st_q.trg_smp)
          begin
            if (st_q.cnt == st_q.rld)
            begin
              st_d.cnt   = CNT_ALL_ONES;
              st_d.ovf_f = 1'b1;
              st_d.ext_f = ~st_q.ext_f;
            end
            else
            begin
              st_d.cnt = st_q.cnt - 16'h1;
            end
          end
          else if (st_q.cnt == CNT_ALL_ONES)
          begin
            st_d.cnt   = st_q.rld;
            st_d.ovf_f = 1'b1;
            if (st_q.down_count_enable)
            begin
              st_d.ext_f = ~st_q.ext_f;
            end
          end
          else
          begin
            st_d.cnt = st_q.cnt + 16'h1;
          end
        end
        default:
        begin
          st_d.cnt = st_q.cnt;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // trigger pin falling edge
    // ----------------------------------------------------------------
    if (trg_fall && st_q.trig_en && st_q.run)
    begin
      case (mode)
        TM2_CAPTURE:
        begin
          st_d.rld   = st_q.cnt;
          st_d.ext_f = 1'b1;
        end
        TM2_RELOAD:
        begin
          if (!st_q.down_count_enable)
          begin
            st_d.cnt   = st_q.rld;
            st_d.ext_f = 1'b1;
          end
        end
        TM2_BAUD:
        begin
          st_d.ext_f = 1'b1;
        end
        default:
        begin
          st_d.ext_f = st_d.ext_f;
        end
      endcase
    end

    // software loads of the counter and reload pair take priority
    if (cnt_wr)
    begin
      st_d.cnt = cnt_wval;
    end
    if (rld_wr)
    begin
      st_d.rld = rld_wval;
    end

    // ----------------------------------------------------------------
    // pin and request outputs
    // ----------------------------------------------------------------
    st_d.pin_oe_b = ~(st_d.oe_en && !st_d.ct_sel);
    if (!st_d.run || st_d.pin_oe_b)
    begin
      st_d.clk_out = st_d.pin_oe_b ? 1'b0 : st_d.clk_out;
    end
    // down-count external flag is a count bit, not a request
    st_d.irq = st_d.ovf_f || (st_d.ext_f && !st_d.down_count_enable);

    // ----------------------------------------------------------------
    // bus: write channels
    // ----------------------------------------------------------------
    if (S_AXI_REQ.awvalid && st_q.aw_rdy)
    begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = S_AXI_REQ.awaddr;
    end
    if (S_AXI_REQ.wvalid && st_q.w_rdy)
    begin
      st_d.w_got = 1'b1;
      st_d.wdata = S_AXI_REQ.wdata;
      st_d.wstrb = S_AXI_REQ.wstrb;
    end
    if (wr_go)
    begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_q.bvalid && S_AXI_REQ.bready)
    begin
      st_d.bvalid = 1'b0;
    end
    st_d.aw_rdy = !st_d.aw_got && !st_d.bvalid;
    st_d.w_rdy  = !st_d.w_got && !st_d.bvalid;

    // ----------------------------------------------------------------
    // bus: read channel, one cycle from address to data
    // ----------------------------------------------------------------
    if (st_q.rvalid && S_AXI_REQ.rready)
    begin
      st_d.rvalid = 1'b0;
    end
    if (S_AXI_REQ.arvalid && st_q.ar_rdy)
    begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      st_d.rdata  = 32'h0;
      if (S_AXI_REQ.araddr[7:4] != 4'h0)
      begin
        st_d.rresp = RESP_SLVERR;
      end
      else
      begin
        case ({S_AXI_REQ.araddr[3:2], 2'b00})
          OFS_CTRL[3:0]:
          begin
            st_d.rdata[CTRL_CP_RL]   = st_q.cp_rl;
            st_d.rdata[CTRL_CT_SEL]  = st_q.ct_sel;
            st_d.rdata[CTRL_RUN]     = st_q.run;
            st_d.rdata[CTRL_TRIG_EN] = st_q.trig_en;
            st_d.rdata[CTRL_TX_BAUD] = st_q.tx_baud;
            st_d.rdata[CTRL_RX_BAUD] = st_q.rx_baud;
            st_d.rdata[CTRL_EXT_F]   = st_q.ext_f;
            st_d.rdata[CTRL_OVF_F]   = st_q.ovf_f;
          end
          OFS_MODE[3:0]:
          begin
            st_d.rdata[MODE_DOWN_COUNT_ENABLE] = st_q.down_count_enable;
            st_d.rdata[MODE_OE]   = st_q.oe_en;
          end
          OFS_COUNT[3:0]:
          begin
            st_d.rdata[15:0] = st_q.cnt;
          end
          OFS_RELOAD[3:0]:
          begin
            st_d.rdata[15:0] = st_q.rld;
          end
          default:
          begin
            st_d.rdata = 32'h0;
          end
        endcase
      end
    end
    st_d.ar_rdy = !st_d.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q          <= '0;
      st_q.cnt      <= CNT_RESET;
      st_q.down_count_enable     <= 1'b0;
      st_q.pin_oe_b <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign S_AXI_RSP.awready    = st_q.aw_rdy;
  assign S_AXI_RSP.wready     = st_q.w_rdy;
  assign S_AXI_RSP.bvalid     = st_q.bvalid;
  assign S_AXI_RSP.bresp      = st_q.bresp;
  assign S_AXI_RSP.arready    = st_q.ar_rdy;
  assign S_AXI_RSP.rvalid     = st_q.rvalid;
  assign S_AXI_RSP.rdata      = st_q.rdata;
  assign S_AXI_RSP.rresp      = st_q.rresp;
  assign CLOCK_OUTPUT_PIN_O    = st_q.clk_out;
  assign CLOCK_OUTPUT_PIN_OE_B = st_q.pin_oe_b;
  assign BAUD_TICK             = st_q.baud_tick;
  assign TIMER_IRQ             = st_q.irq;

endmodule
`default_nettype wire

// file: tm2_monitor.sv
`default_nettype none
module tm2_monitor
  import tm2_pkg::*;
(
  input wire logic                  REF_CLK,
  input wire logic                  RST_B,
  input wire tm2_pkg::tm2_axi_req_s S_AXI_REQ,
  input wire tm2_pkg::tm2_axi_rsp_s S_AXI_RSP,
  input wire logic                  CLOCK_OUTPUT_PIN_O,
  input wire logic                  CLOCK_OUTPUT_PIN_OE_B,
  input wire logic                  BAUD_TICK
);
  // ------------------------------
  // bus and pin checks
  // ------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  logic ar_hs;
  logic wr_hs;
  assign ar_hs = S_AXI_REQ.arvalid && S_AXI_RSP.arready;
  assign wr_hs = S_AXI_REQ.awvalid && S_AXI_RSP.awready && S_AXI_REQ.wvalid && S_AXI_RSP.wready;

  a_wr_answer:
    assert property (wr_hs |-> ##2 S_AXI_RSP.bvalid) else $error("write answer late");
  a_wr_busy:
    assert property (S_AXI_RSP.bvalid |-> !S_AXI_RSP.awready && !S_AXI_RSP.wready) else $error("ready while busy");
  a_rd_answer:
    assert property (ar_hs |=> S_AXI_RSP.rvalid) else $error("read answer late");
  a_rd_busy:
    assert property (S_AXI_RSP.rvalid |-> !S_AXI_RSP.arready) else $error("arready while rvalid");
  a_rd_error:
    assert property (ar_hs && S_AXI_REQ.araddr[7:4] != 4'h0 |=> S_AXI_RSP.rresp == RESP_SLVERR
      && S_AXI_RSP.rdata == 32'h0) else $error("unmapped read not refused");
  a_oe_change:
    assert property ($changed(CLOCK_OUTPUT_PIN_OE_B) |-> S_AXI_RSP.bvalid || $past(S_AXI_RSP.bvalid))
    else $error("pin enable moved without a write");
  a_pin_idle:
    assert property (CLOCK_OUTPUT_PIN_OE_B && $past(CLOCK_OUTPUT_PIN_OE_B) && $past(CLOCK_OUTPUT_PIN_OE_B, 2)
      |-> !CLOCK_OUTPUT_PIN_O) else $error("clock out active while released");
  a_clk_half:
    assert property ($changed(CLOCK_OUTPUT_PIN_O) |=> $stable(CLOCK_OUTPUT_PIN_O) || CLOCK_OUTPUT_PIN_OE_B)
    else $error("clock out half period too short");
  a_tick_single:
    assert property (BAUD_TICK |=> !BAUD_TICK) else $error("baud tick wider than one cycle");
endmodule

bind tm2_timer tm2_monitor mon_u (
  .REF_CLK(REF_CLK),
  .RST_B(RST_B),
  .S_AXI_REQ(S_AXI_REQ),
  .S_AXI_RSP(S_AXI_RSP),
  .CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O),
  .CLOCK_OUTPUT_PIN_OE_B(CLOCK_OUTPUT_PIN_OE_B),
  .BAUD_TICK(BAUD_TICK)
);
`default_nettype wire

// file: tm2_pin_model.sv
`default_nettype none
module tm2_pin_model (
  input  wire logic clk,
  output var  logic cnt_pin,
  output var  logic trig_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // external count and trigger source
  // ------------------------------
  // 16 clocks a level: one machine cycle plus sync margin
  initial
  begin
    cnt_pin = 1'b1;
    trig_pin = 1'b1;
  end

  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (16) @(posedge clk);
      cnt_pin <= 1'b0;
      repeat (16) @(posedge clk);
      cnt_pin <= 1'b1;
    end
  endtask

  task automatic trig_set(input logic v);
    trig_pin <= v;
    repeat (16) @(posedge clk);
  endtask

  task automatic trig_fall();
    trig_set(1'b0);
    trig_set(1'b1);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top
  import tm2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // clock, dut, partner
  // ------------------------------
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  tm2_axi_req_s req = '0;
  tm2_axi_rsp_s rsp;
  logic         pin_o, oe_b, tick, irq, cnt_pin, trig_pin;
  logic [33:0]  rq[$];
  int           error_cnt = 0;
  int           samples_checked = 0;
  wire logic    pin_lvl = oe_b ? cnt_pin : pin_o;

  always #50 clk = ~clk;

  tm2_timer dut_u (.REF_CLK(clk), .RST_B(rst_b), .S_AXI_REQ(req), .S_AXI_RSP(rsp),
    .CLOCK_OUTPUT_PIN_I(pin_lvl), .CLOCK_OUTPUT_PIN_O(pin_o), .CLOCK_OUTPUT_PIN_OE_B(oe_b),
    .TRIGGER_PIN(trig_pin), .BAUD_TICK(tick), .TIMER_IRQ(irq));
  tm2_pin_model pm_u (.clk(clk), .cnt_pin(cnt_pin), .trig_pin(trig_pin));

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic bump(ref int n);
    @(posedge clk);
    n++;
    if (n > 300)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // ready lines stay high between transfers, so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    int n = 0;
    logic [1:0] p = 2'b11;
    rq.push_back({er, 32'h0});
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {16'h0, d};
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    while (p != 2'b00)
    begin
      bump(n);
      if (rsp.awready) p[1] = 1'b0;
      if (rsp.wready) p[0] = 1'b0;
      req.awvalid <= p[1];
      req.wvalid <= p[0];
    end
    do bump(n); while (!rsp.bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = RESP_OKAY);
    int n = 0;
    rq.push_back({er, 16'h0, e});
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do bump(n); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do bump(n); while (!rsp.rvalid);
  endtask

  task automatic settle();
    repeat (40) @(posedge clk);
  endtask

  // both half periods of the clock out, in clocks
  task automatic halves(input int h);
    int n = 0;
    int k;
    logic v;
    // start on a rising edge, never inside a half period
    while (pin_o) bump(n);
    while (!pin_o) bump(n);
    repeat (2)
    begin
      v = pin_o;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (pin_o === v && k < 50);
      chk(34'(k), 34'(h));
    end
  endtask

  always @(posedge clk)
  begin
    if (rsp.bvalid && req.bready)
      chk({rsp.bresp, 32'h0}, rq.pop_front());
    if (rsp.rvalid && req.rready)
      chk({rsp.rresp, rsp.rdata}, rq.pop_front());
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial
  begin
    logic [15:0] r;
    int k;
    void'($urandom(32'h38d8e407));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 4; k++)
      rd(8'(4 * k), 16'h0);
    rd(8'h10, 16'h0, RESP_SLVERR);
    wr(8'h10, 16'hffff, RESP_SLVERR);
    repeat (4)
    begin
      r = 16'($urandom);
      wr(OFS_COUNT, r);
      rd(OFS_COUNT, r);
    end
    // high byte lane only: low byte must survive
    wr(OFS_COUNT, 16'h5a5a, RESP_OKAY, 4'h2);
    r = {8'h5a, r[7:0]};
    rd(OFS_COUNT, r);
    // run window of 120 clocks holds exactly 10 machine cycles
    wr(OFS_CTRL, 16'h0004);
    repeat (117) @(posedge clk);
    wr(OFS_CTRL, 16'h0000);
    rd(OFS_COUNT, r + 16'd10);
    wr(OFS_RELOAD, 16'hfff0);
    wr(OFS_COUNT, 16'hfffe);
    wr(OFS_CTRL, 16'h0004);
    repeat (45) @(posedge clk);
    chk({33'h0, irq}, 34'h1);
    wr(OFS_CTRL, 16'h0000);
    rd(OFS_COUNT, 16'hfff2);
    chk({33'h0, irq}, 34'h0);
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_CTRL, 16'h0006);
    pm_u.pulse(5);
    settle();
    rd(OFS_COUNT, 16'h0005);
    wr(OFS_CTRL, 16'h000f);
    pm_u.trig_fall();
    settle();
    rd(OFS_RELOAD, 16'h0005);
    rd(OFS_CTRL, 16'h004f);
    chk({33'h0, irq}, 34'h1);
    wr(OFS_RELOAD, 16'h1234);
    wr(OFS_CTRL, 16'h000e);
    pm_u.trig_fall();
    settle();
    rd(OFS_COUNT, 16'h1234);
    rd(OFS_CTRL, 16'h004e);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0001);
    wr(OFS_RELOAD, 16'h0010);
    wr(OFS_COUNT, 16'h0011);
    pm_u.trig_set(1'b0);
    wr(OFS_CTRL, 16'h0006);
    pm_u.pulse(2);
    settle();
    rd(OFS_COUNT, 16'hffff);
    rd(OFS_CTRL, 16'h00c6);
    wr(OFS_CTRL, 16'h0046);
    repeat (3) @(posedge clk);
    chk({33'h0, irq}, 34'h0);
    pm_u.trig_set(1'b1);
    pm_u.pulse(1);
    settle();
    rd(OFS_COUNT, 16'h0010);
    rd(OFS_CTRL, 16'h0086);
    // clock out, then shared with baud generation
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_MODE, 16'h0002);
    wr(OFS_RELOAD, 16'hfffe);
    wr(OFS_COUNT, 16'hfffe);
    wr(OFS_CTRL, 16'h0004);
    settle();
    chk({33'h0, oe_b}, 34'h0);
    halves(4);
    rd(OFS_CTRL, 16'h0004);
    chk({33'h0, irq}, 34'h0);
    wr(OFS_CTRL, 16'h0014);
    k = 0;
    repeat (64)
    begin
      @(posedge clk);
      k += int'(tick);
    end
    chk(34'(k), 34'd16);
    halves(4);
    rd(OFS_CTRL, 16'h0014);
    wr(OFS_CTRL, 16'h0006);
    settle();
    chk({33'h0, oe_b}, 34'h1);
    wr(OFS_COUNT, 16'h0000);
    pm_u.pulse(3);
    settle();
    rd(OFS_COUNT, 16'h0003);
    complete_run();
  end
endmodule
`default_nettype wire
